/* rtl/ctt_regs.vh */
// Test register numbers, field positions and reset values
`ifndef CTT_REGS_VH
`define CTT_REGS_VH

// Test register numbers
`define CTT_NUM_CACHE_TEST_DATA 3'h3
`define CTT_NUM_CACHE_TEST_STATUS 3'h4
`define CTT_NUM_CACHE_TEST_CONTROL 3'h5
`define CTT_NUM_TRANSLATION_COMMAND_TEST 3'h6
`define CTT_NUM_TRANSLATION_DATA_TEST 3'h7

// cache_test_control fields
`define CTT_CTL_OP_HI 1
`define CTT_CTL_OP_LO 0
`define CTT_CTL_ENT_HI 3
`define CTT_CTL_ENT_LO 2
`define CTT_CTL_SET_HI 10
`define CTT_CTL_SET_LO 4
`define CTT_OP_BUFFER 2'h0
`define CTT_OP_WRITE 2'h1
`define CTT_OP_READ 2'h2
`define CTT_OP_FLUSH 2'h3

// cache_test_status fields
`define CTT_STS_TAG_HI 31
`define CTT_STS_TAG_LO 11
`define CTT_STS_VALID 10
`define CTT_STS_LRU_HI 9
`define CTT_STS_LRU_LO 7
`define CTT_STS_SETV_HI 6
`define CTT_STS_SETV_LO 3

// translation_command_test fields
`define CTT_CMD_LIN_HI 31
`define CTT_CMD_LIN_LO 12
`define CTT_CMD_SET_HI 14
`define CTT_CMD_SET_LO 12
`define CTT_CMD_TAG_HI 31
`define CTT_CMD_TAG_LO 15
`define CTT_CMD_V 11
`define CTT_CMD_D 10
`define CTT_CMD_DN 9
`define CTT_CMD_U 8
`define CTT_CMD_UN 7
`define CTT_CMD_W 6
`define CTT_CMD_WN 5
`define CTT_CMD_OP 0

// translation_data_test fields
`define CTT_TDT_DATA_HI 31
`define CTT_TDT_DATA_LO 10
`define CTT_TDT_LRU_HI 9
`define CTT_TDT_LRU_LO 7
`define CTT_TDT_HIT 4
`define CTT_TDT_PTR_HI 3
`define CTT_TDT_PTR_LO 2

// Reset values
`define CTT_RST_WORD 32'h0000_0000
`define CTT_RST_LRU 3'h0
`define CTT_RST_VALID 4'h0

`endif

/* rtl/ctt_test_regs.v */
// Cache and translation buffer test registers with their arrays
`timescale 1ns/1ps
`include "ctt_regs.vh"

// Notes on behaviour
// RL1 - Control 00: writing cache data register fills selected fill-buffer word
// RL2 - Software fills the fill buffer in four entry-select passes
// RL3 - Software loads status with tag and valid bit before commit
// RL4 - Control 01 copies fill buffer, tag and valid into set/entry
// RL5 - Test write updates set LRU through the normal update logic
// RL6 - Test writes only while line replacement is disabled
// RL7 - Control 10 reads selected set and entry into read buffer
// RL8 - Test read captures tag, valid, set LRU and four valids
// RL9 - Test read loads whole 128-bit entry into read buffer
// RL10 - Control 00: reading data register returns selected read-buffer word
// RL11 - Read buffer and status must be read before memory accesses
// RL12 - Control 11 flushes; set and entry fields ignored
// RL13 - Flush clears all LRU and valid bits, keeps tags and data
// RL14 - Test-register flush runs no external flush bus cycle
// RL15 - Translation buffer is four ways of eight sets
// RL16 - Translation data entry: 20-bit page address, cache-disable, write-through
// RL17 - Translation tag entry: 17-bit tag plus valid, user, write, dirty
// RL18 - Three-bit pseudo-LRU per translation set, same as cache
// RL19 - Writing command register launches translation write or lookup
// RL20 - Command holds address 31:12, protection 11:5, operation bit 0
// RL21 - Low three address bits pick the set, upper 17 the tag
// RL22 - Dirty, user and write given as true/complement pairs
// RL23 - Pair 01 stores 0, 10 stores 1; lookup 00 miss, 11 any
// RL24 - Operation bit 0 writes, 1 looks up
// RL25 - Control register: 7-bit set, 2-bit entry, 2-bit control
module ctt_test_regs #(
    parameter CSETS = 128,
    parameter CSETW = 7,
    parameter TSETS = 8,
    parameter TSETW = 3
) (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Test register moves
    input wire trWr,
    input wire trRd,
    input wire [2:0] trNum,
    input wire [31:0] trWdata,
    output reg [31:0] trRdata_r,
    // Cache control context
    input wire cacheDisableFlag,
    input wire flushInsn,
    output reg flushBusCycle_r
);

    reg [31:0] statusReg_r;
    reg [31:0] controlReg_r;
    reg [31:0] commandReg_r;
    reg [31:0] tdataReg_r;
    reg [127:0] fillBuf_r;
    reg [127:0] readBuf_r;

    // Cache arrays: data and tag have no reset, only valid and LRU do
    reg [127:0] cacheData [0:CSETS*4-1];
    reg [20:0] cacheTag [0:CSETS*4-1];
    reg [3:0] cacheValid [0:CSETS-1];
    reg [2:0] cacheLru [0:CSETS-1];

    // Translation buffer arrays
    reg [21:0] tlbData [0:TSETS*4-1]; // RL15 RL16
    reg [20:0] tlbTag [0:TSETS*4-1]; // RL17
    reg [2:0] tlbLru [0:TSETS-1]; // RL18

    // One loop variable per process so each has a single driver
    integer i;
    integer j;
    integer k;

    // Pseudo-LRU victim: bit0 picks the half, bit1/bit2 the way in it
    function [1:0] plruVictim;
        input [2:0] lru;
        begin
            if (!lru[0]) begin
                plruVictim = lru[1] ? 2'h1 : 2'h0;
            end else begin
                plruVictim = lru[2] ? 2'h3 : 2'h2;
            end
        end
    endfunction

    // Pseudo-LRU update after touching one way
    function [2:0] plruUpd;
        input [2:0] lru;
        input [1:0] way;
        begin
            case (way)
                2'h0: plruUpd = {lru[2], 2'b11};
                2'h1: plruUpd = {lru[2], 2'b01};
                2'h2: plruUpd = {1'b1, lru[1], 1'b0};
                default: plruUpd = {1'b0, lru[1], 1'b0};
            endcase
        end
    endfunction

    // Decoded control fields
    wire [1:0] ctlOp = controlReg_r[`CTT_CTL_OP_HI:`CTT_CTL_OP_LO]; // RL25
    wire [1:0] ctlEnt = controlReg_r[`CTT_CTL_ENT_HI:`CTT_CTL_ENT_LO];
    wire [CSETW-1:0] ctlSet = trWdata[`CTT_CTL_SET_HI:`CTT_CTL_SET_LO];
    wire [1:0] newOp = trWdata[`CTT_CTL_OP_HI:`CTT_CTL_OP_LO];
    wire [1:0] newEnt = trWdata[`CTT_CTL_ENT_HI:`CTT_CTL_ENT_LO];
    wire [CSETW+1:0] newIdx = {ctlSet, newEnt};

    wire wrData = trWr && trNum == `CTT_NUM_CACHE_TEST_DATA;
    wire wrStatus = trWr && trNum == `CTT_NUM_CACHE_TEST_STATUS;
    wire wrControl = trWr && trNum == `CTT_NUM_CACHE_TEST_CONTROL;
    wire wrCommand = trWr && trNum == `CTT_NUM_TRANSLATION_COMMAND_TEST;
    wire wrTdata = trWr && trNum == `CTT_NUM_TRANSLATION_DATA_TEST;

    // Testability write refused while replacement is still enabled
    wire cacheWr = wrControl && newOp == `CTT_OP_WRITE
        && cacheDisableFlag; // RL4 RL6
    wire cacheRd = wrControl && newOp == `CTT_OP_READ; // RL7
    wire testFlush = wrControl && newOp == `CTT_OP_FLUSH; // RL12

    // Translation command decode
    wire [TSETW-1:0] cmdSet = trWdata[`CTT_CMD_SET_HI:`CTT_CMD_SET_LO]; // RL21
    wire [16:0] cmdTag = trWdata[`CTT_CMD_TAG_HI:`CTT_CMD_TAG_LO]; // RL21
    wire cmdLookup = trWdata[`CTT_CMD_OP]; // RL24
    wire tlbWr = wrCommand && !cmdLookup; // RL19 RL24
    wire tlbLook = wrCommand && cmdLookup; // RL19 RL24
    wire [1:0] tlbWay = tdataReg_r[`CTT_TDT_HIT] ?
        tdataReg_r[`CTT_TDT_PTR_HI:`CTT_TDT_PTR_LO] :
        plruVictim(tlbLru[cmdSet]);
    // Stored tag: {tag17, V, D, U, W}; pair 10 stores 1, 01 stores 0
    wire [20:0] tlbNewTag = {cmdTag, trWdata[`CTT_CMD_V],
        trWdata[`CTT_CMD_D], trWdata[`CTT_CMD_U],
        trWdata[`CTT_CMD_W]}; // RL22 RL23

    // Lookup compare per way
    reg [3:0] wayHit;
    reg [1:0] hitWay;
    reg [2:0] hitCount;
    reg [20:0] st;
    always @* begin
        wayHit = 4'h0;
        hitWay = 2'h0;
        hitCount = 3'h0;
        st = 21'h0;
        for (j = 0; j < 4; j = j + 1) begin
            st = tlbTag[{cmdSet, j[1:0]}];
            // Each pair: true bit allows stored 1, complement allows 0
            wayHit[j] = st[20:4] == cmdTag
                && st[3] == trWdata[`CTT_CMD_V]
                && (st[2] ? trWdata[`CTT_CMD_D] : trWdata[`CTT_CMD_DN])
                && (st[1] ? trWdata[`CTT_CMD_U] : trWdata[`CTT_CMD_UN])
                && (st[0] ? trWdata[`CTT_CMD_W] : trWdata[`CTT_CMD_WN]);
            if (wayHit[j]) begin
                hitWay = j[1:0];
                hitCount = hitCount + 3'h1;
            end
        end
    end // RL23
    // Same address in two ways of a set never counts as a hit
    wire tlbHit = hitCount == 3'h1;

    // Test register state
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            statusReg_r <= `CTT_RST_WORD;
            controlReg_r <= `CTT_RST_WORD;
            commandReg_r <= `CTT_RST_WORD;
            tdataReg_r <= `CTT_RST_WORD;
            fillBuf_r <= 128'h0;
            readBuf_r <= 128'h0;
            trRdata_r <= `CTT_RST_WORD;
            flushBusCycle_r <= 1'b0;
        end else begin
            // Only the flush instruction announces itself on the bus
            flushBusCycle_r <= flushInsn && !testFlush; // RL14
            if (wrData && ctlOp == `CTT_OP_BUFFER) begin
                fillBuf_r[ctlEnt*32 +: 32] <= trWdata; // RL1
            end
            if (wrControl) begin
                controlReg_r <= trWdata;
            end
            if (wrCommand) begin
                commandReg_r <= trWdata; // RL20
            end
            if (cacheRd) begin
                // Held until the next test read; ordering is up to software
                readBuf_r <= cacheData[newIdx]; // RL9 RL11
                statusReg_r <= {cacheTag[newIdx],
                    cacheValid[ctlSet][newEnt], cacheLru[ctlSet],
                    cacheValid[ctlSet], 3'h0}; // RL8
            end else if (wrStatus) begin
                statusReg_r <= trWdata; // RL3
            end
            if (tlbLook) begin
                if (tlbHit) begin
                    // LRU reported as it stood before this lookup
                    tdataReg_r <= {tlbData[{cmdSet, hitWay}],
                        tlbLru[cmdSet], 2'h0, 1'b1, hitWay, 2'h0};
                end else begin
                    tdataReg_r[`CTT_TDT_HIT] <= 1'b0;
                end
            end else if (wrTdata) begin
                tdataReg_r <= trWdata;
            end
            if (trRd) begin
                if (trNum == `CTT_NUM_CACHE_TEST_DATA) begin
                    trRdata_r <= ctlOp == `CTT_OP_BUFFER ?
                        readBuf_r[ctlEnt*32 +: 32] : `CTT_RST_WORD; // RL10
                end else if (trNum == `CTT_NUM_CACHE_TEST_STATUS) begin
                    trRdata_r <= statusReg_r;
                end else if (trNum == `CTT_NUM_CACHE_TEST_CONTROL) begin
                    trRdata_r <= controlReg_r;
                end else if (trNum == `CTT_NUM_TRANSLATION_COMMAND_TEST) begin
                    trRdata_r <= commandReg_r;
                end else if (trNum == `CTT_NUM_TRANSLATION_DATA_TEST) begin
                    trRdata_r <= tdataReg_r;
                end else begin
                    trRdata_r <= `CTT_RST_WORD;
                end
            end
        end
    end

    // Cache valid and LRU; a flush clears every set in one cycle
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < CSETS; i = i + 1) begin
                cacheValid[i] <= `CTT_RST_VALID;
                cacheLru[i] <= `CTT_RST_LRU;
            end
        end else if (testFlush || flushInsn) begin
            for (i = 0; i < CSETS; i = i + 1) begin
                cacheValid[i] <= `CTT_RST_VALID; // RL13
                cacheLru[i] <= `CTT_RST_LRU; // RL13
            end
        end else if (cacheWr) begin
            cacheValid[ctlSet][newEnt] <= statusReg_r[`CTT_STS_VALID]; // RL4
            cacheLru[ctlSet] <= plruUpd(cacheLru[ctlSet], newEnt); // RL5
        end
    end

    // Cache tag and data arrays; untouched by flush
    always @(posedge ref_clk) begin
        if (cacheWr) begin
            cacheData[newIdx] <= fillBuf_r; // RL4
            cacheTag[newIdx] <=
                statusReg_r[`CTT_STS_TAG_HI:`CTT_STS_TAG_LO]; // RL4
        end
    end

    // Translation LRU: writes and hits make the way most recent
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (k = 0; k < TSETS; k = k + 1) begin
                tlbLru[k] <= `CTT_RST_LRU;
            end
        end else if (tlbWr) begin
            tlbLru[cmdSet] <= plruUpd(tlbLru[cmdSet], tlbWay); // RL18
        end else if (tlbLook && tlbHit) begin
            tlbLru[cmdSet] <= plruUpd(tlbLru[cmdSet], hitWay); // RL18
        end
    end

    // Translation tag and data arrays, filled only by test writes here
    always @(posedge ref_clk) begin
        if (tlbWr) begin
            tlbTag[{cmdSet, tlbWay}] <= tlbNewTag; // RL17 RL23
            tlbData[{cmdSet, tlbWay}] <=
                tdataReg_r[`CTT_TDT_DATA_HI:`CTT_TDT_DATA_LO]; // RL16
        end
    end

endmodule // ctt_test_regs

/* verif/ctt_regs_properties.sv */
// Port-level properties of the test register block
`timescale 1ns/1ps
module ctt_regs_properties (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Register moves
    input wire trWr,
    input wire trRd,
    input wire [2:0] trNum,
    input wire [31:0] trWdata,
    input wire [31:0] trRdata_r,
    // Flush
    input wire flushInsn,
    input wire flushBusCycle_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_ctl(op);
        trWr && trNum == 3'h5 && trWdata[1:0] == op;
    endsequence
    sequence s_rd(n);
        trRd && trNum == n;
    endsequence
    sequence s_miss;
        trWr && trNum == 3'h6 && trWdata[0] && trWdata[10:9] == 2'h0;
    endsequence
    property p_flushQuiet;
        s_ctl(2'h3) ##0 !flushInsn |=> !flushBusCycle_r;
    endproperty
    a_flushQuiet: assert property (p_flushQuiet)
        else $error("bus flush cycle after register flush");
    property p_busCause;
        flushBusCycle_r |-> $past(flushInsn);
    endproperty
    a_busCause: assert property (p_busCause)
        else $error("bus flush cycle without flush instruction");
    property p_unmapped;
        trRd && trNum < 3'h3 |=> trRdata_r == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rdHold;
        !trRd |=> $stable(trRdata_r);
    endproperty
    a_rdHold: assert property (p_rdHold)
        else $error("read data moved without a read");
    property p_ctlBack;
        (trWr && trNum == 3'h5) ##1 s_rd(3'h5)
            |=> trRdata_r[10:0] == $past(trWdata[10:0], 2);
    endproperty
    a_ctlBack: assert property (p_ctlBack)
        else $error("control fields not read back");
    property p_dataOp;
        (trWr && trNum == 3'h5 && trWdata[1:0] != 2'h0) ##1 s_rd(3'h3)
            |=> trRdata_r == 32'h0000_0000;
    endproperty
    a_dataOp: assert property (p_dataOp)
        else $error("data read outside buffer mode not zero");
    property p_flushSts;
        s_ctl(2'h3) ##1 s_ctl(2'h2) ##1 s_rd(3'h4)
            |=> trRdata_r[9:3] == 7'h00;
    endproperty
    a_flushSts: assert property (p_flushSts)
        else $error("LRU or valid bits survive flush");
    property p_forcedMiss;
        s_miss ##1 s_rd(3'h7) |=> !trRdata_r[4];
    endproperty
    a_forcedMiss: assert property (p_forcedMiss)
        else $error("forced miss pair reported a hit");
endmodule // ctt_regs_properties

bind ctt_test_regs ctt_regs_properties u_ctt_regs_properties (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .trWr(trWr),
    .trRd(trRd),
    .trNum(trNum),
    .trWdata(trWdata),
    .trRdata_r(trRdata_r),
    .flushInsn(flushInsn),
    .flushBusCycle_r(flushBusCycle_r)
);

/* verif/ctt_mover.sv */
// Processor side model issuing test register moves
`timescale 1ns/1ps
module ctt_mover (
    // Clock
    input wire ref_clk,
    // Register moves
    output logic trWr,
    output logic trRd,
    output logic [2:0] trNum,
    output logic [31:0] trWdata,
    input wire [31:0] trRdata_r
);
    initial begin
        trWr = 1'b0;
        trRd = 1'b0;
        trNum = 3'h0;
        trWdata = 32'h0000_0000;
    end
    // Strobe stays up so back-to-back moves need no idle cycle
    task automatic wrReg(input logic [2:0] n, input logic [31:0] d);
        trWr <= 1'b1;
        trRd <= 1'b0;
        trNum <= n;
        trWdata <= d;
        @(posedge ref_clk);
    endtask
    // Write data is meaningless on reads, so it toggles
    task automatic rdReg(input logic [2:0] n, output logic [31:0] d);
        trWr <= 1'b0;
        trRd <= 1'b1;
        trNum <= n;
        trWdata <= ~trWdata;
        @(posedge ref_clk);
        trRd <= 1'b0;
        @(posedge ref_clk);
        d = trRdata_r;
    endtask
    task automatic idle;
        trWr <= 1'b0;
        trRd <= 1'b0;
        @(posedge ref_clk);
    endtask
endmodule // ctt_mover

/* verif/test_cache_tlb_test_register_access.sv */
// Self-checking bench for the test register block
`timescale 1ns/1ps
module test_cache_tlb_test_register_access;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cacheDisableFlag = 1'b1;
    logic flushInsn = 1'b0;
    wire trWr;
    wire trRd;
    wire [2:0] trNum;
    wire [31:0] trWdata;
    wire [31:0] trRdata_r;
    wire flushBusCycle_r;
    logic [31:0] lkCmd [5] = '{32'h1234_BCC1, 32'h1234_BD41,
        32'h1234_BFE1, 32'h1234_B8C1, 32'h1236_3CC1};
    logic [31:0] lkMask [5] = '{32'hFFFF_FC1C, 32'h0000_0010,
        32'hFFFF_FC1C, 32'h0000_0010, 32'h0000_0010};
    logic [31:0] lkExp [5] = '{32'hABCD_E814, 32'h0000_0000,
        32'hABCD_E814, 32'h0000_0000, 32'h0000_0000};
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    always #50 ref_clk = ~ref_clk;
    ctt_test_regs u_ctt_test_regs (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .trWr(trWr),
        .trRd(trRd),
        .trNum(trNum),
        .trWdata(trWdata),
        .trRdata_r(trRdata_r),
        .cacheDisableFlag(cacheDisableFlag),
        .flushInsn(flushInsn),
        .flushBusCycle_r(flushBusCycle_r)
    );
    ctt_mover u_ctt_mover (
        .ref_clk(ref_clk),
        .trWr(trWr),
        .trRd(trRd),
        .trNum(trNum),
        .trWdata(trWdata),
        .trRdata_r(trRdata_r)
    );
    task automatic stop_test;
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] n, input logic [31:0] d);
        u_ctt_mover.wrReg(n, d);
    endtask
    task automatic rdChk(input logic [2:0] n, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] g;
        u_ctt_mover.rdReg(n, g);
        chk(g & m, e);
    endtask
    // Reads set 5 entry 2 back through the read buffer
    task automatic checkLine(input logic [31:0] tagv);
        wr(3'h5, 32'h0000_005A);
        rdChk(3'h4, 32'hFFFF_FC00, tagv);
        wr(3'h5, 32'h0000_005A);
        rdChk(3'h3, 32'hFFFF_FFFF, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            wr(3'h5, 32'(k) << 2);
            rdChk(3'h3, 32'hFFFF_FFFF, 32'hC0DE_0000 | 32'(k));
        end
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        chk(32'(flushBusCycle_r), 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            wr(3'h5, 32'(k) << 2);
            wr(3'h3, 32'hC0DE_0000 | 32'(k));
        end
        wr(3'h4, 32'h5A5A_4C00);
        wr(3'h5, 32'h0000_0059);
        checkLine(32'h5A5A_4C00);
        rdChk(3'h4, 32'hFFFF_FFFF, 32'h5A5A_4E20);
        cacheDisableFlag <= 1'b0;
        wr(3'h4, 32'h0000_0000);
        wr(3'h5, 32'h0000_0059);
        checkLine(32'h5A5A_4C00);
        cacheDisableFlag <= 1'b1;
        wr(3'h5, 32'h0000_07FF);
        checkLine(32'h5A5A_4800);
        wr(3'h5, 32'h0000_07FC);
        rdChk(3'h5, 32'h0000_07FF, 32'h0000_07FC);
        rdChk(3'h0, 32'hFFFF_FFFF, 32'h0000_0000);
        u_ctt_mover.idle();
        flushInsn <= 1'b1;
        @(posedge ref_clk);
        flushInsn <= 1'b0;
        @(posedge ref_clk);
        chk(32'(flushBusCycle_r), 32'h0000_0001);
        for (int w = 0; w < 4; w++) begin
            wr(3'h7, 32'hABCD_E810 | (32'(w) << 2));
            wr(3'h6, 32'h1234_3CC0 + (32'(w) << 15));
        end
        for (int i = 0; i < 5; i++) begin
            wr(3'h6, lkCmd[i]);
            rdChk(3'h7, lkMask[i], lkExp[i]);
        end
        stop_test();
    end
endmodule // test_cache_tlb_test_register_access
